// ==== core/scc_pkg.sv ====
/*
 stop condition control package: control register layout, reset values,
 stop sequence states and bus timing counts.
 assumes a 25 MHz controller clock.
*/
package scc_pkg;
	localparam int CLK_MHZ = 25;
	localparam int CLK_PERIOD_NS = 40;
	// register offsets
	localparam logic [1:0] ADDR_CTRL = 2'h0;
	localparam logic [1:0] ADDR_STAT = 2'h1;
	localparam logic [1:0] ADDR_FLAG = 2'h2;
	// control register bit positions
	localparam int BIT_STOP = 0;
	localparam int BIT_START = 1;
	localparam int BIT_ACK_EN = 2;
	localparam int BIT_WTIM = 3;
	localparam int BIT_WREL = 5;
	localparam int BIT_LREL = 6;
	localparam int BIT_ENABLE = 7;
	// status register bit positions
	localparam int BIT_TRC = 3;
	localparam int BIT_MSTS = 7;
	// flag register bit positions
	localparam int BIT_RSV_DIS = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	// stop setup time, ns; least time rounds up
	localparam int T_STOP_SETUP_NS = 4000;
	localparam int STOP_SETUP_CYC = (T_STOP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// scl half period for the ninth clock, ns
	localparam int T_SCL_HALF_NS = 5000;
	localparam int SCL_HALF_CYC = (T_SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [2:0] {
		SCC_IDLE = 3'b000,
		SCC_SDA_LOW = 3'b001,
		SCC_SCL_HIGH = 3'b010,
		SCC_SETUP = 3'b011,
		SCC_DONE = 3'b100
	} scc_state_e;
	// bus line drive bundle
	typedef struct packed {
		logic scl_oe;
		logic sda_oe;
	} scc_drive_s;
endpackage

// ==== core/scc_timer.sv ====
/*
 down counter whose done output holds high once a loaded count has elapsed.
 assumes load and count come from logic on the same clock.
*/
`timescale 1ns/1ns
module scc_timer #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// control
	input wire logic i_load,
	input wire logic [WIDTH-1:0] i_count,
	// result
	output logic o_done
);
	logic [WIDTH-1:0] count;
	wire zero = (count == '0);
	// count down after load, done holds at zero
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			count <= '0;
		end else if (i_load) begin
			count <= i_count;
		end else if (!zero) begin
			count <= count - 1'b1;
		end
	end
	assign o_done = zero & ~i_load;
endmodule

// ==== core/scc_stop_ctrl.sv ====
/*
 stop condition control for a two-wire serial bus controller: control,
 flag and status registers, stop trigger, stop pin sequence, ninth clock
 acknowledge and wait release.
 assumes open-drain scl/sda pins resolved outside, and a byte engine that
 reports wait, ninth clock, start generated, stop detected and lost arbitration.
*/
`timescale 1ns/1ns
module scc_stop_ctrl
	import scc_pkg::*;
#(
	parameter int TWIDTH = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// register port
	input wire logic [1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// byte engine events
	input wire logic i_in_wait,
	input wire logic i_ninth_clk,
	input wire logic i_receiving,
	input wire logic i_transmit_set,
	input wire logic i_start_gen,
	input wire logic i_stop_det,
	input wire logic i_arb_lost,
	// pins
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_scl_out,
	output logic o_scl_oe,
	output logic o_sda_out,
	output logic o_sda_oe,
	// state out
	output logic o_stop_busy,
	output logic o_wait_release
);
	// synchronised pins
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
		end else begin
			scl_sync <= {scl_sync[0], i_scl};
			sda_sync <= {sda_sync[0], i_sda};
		end
	end
	wire scl_high = scl_sync[1];

	logic stop_trigger;
	logic start_trigger;
	logic ack_enable;
	logic wait_timing_select;
	logic controller_enable;
	logic reservation_disable;
	logic master_status_flag;
	logic transmit_receive_status;
	logic wait_release;
	scc_state_e state, next_state;
	scc_drive_s drive, next_drive;

	// write decode
	wire wr_ctrl = i_wr & (i_addr == ADDR_CTRL);
	wire wr_flag = i_wr & (i_addr == ADDR_FLAG);
	wire set_stop = wr_ctrl & i_wdata[BIT_STOP];
	wire set_start = wr_ctrl & i_wdata[BIT_START];
	wire set_lrel = wr_ctrl & i_wdata[BIT_LREL];
	wire new_enable = wr_ctrl ? i_wdata[BIT_ENABLE] : controller_enable;
	wire disabling = controller_enable & ~new_enable;
	wire stop_done = (state == SCC_DONE);
	// abort paths: forced release or disable
	wire abort = set_lrel | ~new_enable;

	// control register; stop trigger set only by software
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stop_trigger <= CTRL_RESET[BIT_STOP];
			start_trigger <= CTRL_RESET[BIT_START];
			ack_enable <= CTRL_RESET[BIT_ACK_EN];
			wait_timing_select <= CTRL_RESET[BIT_WTIM];
			controller_enable <= CTRL_RESET[BIT_ENABLE];
			reservation_disable <= FLAG_RESET[BIT_RSV_DIS];
		end else begin
			controller_enable <= new_enable;
			if (wr_ctrl) begin
				ack_enable <= i_wdata[BIT_ACK_EN];
				wait_timing_select <= i_wdata[BIT_WTIM];
			end
			if (wr_flag)
				reservation_disable <= i_wdata[BIT_RSV_DIS];
			// trigger clears on done/release/disable, set wins otherwise
			if (abort)
				stop_trigger <= 1'b0;
			else if (set_stop & ~set_start)
				stop_trigger <= 1'b1;
			else if (stop_done)
				stop_trigger <= 1'b0;
			if (abort | i_arb_lost | i_start_gen)
				start_trigger <= 1'b0;
			else if (set_start & ~set_stop)
				start_trigger <= 1'b1;
		end
	end

	// master status and transmit/receive status
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			master_status_flag <= 1'b0;
			transmit_receive_status <= 1'b0;
		end else begin
			if (i_start_gen & controller_enable)
				master_status_flag <= 1'b1;
			else if (i_stop_det | i_arb_lost | set_lrel | disabling)
				master_status_flag <= 1'b0;
			if (i_transmit_set)
				transmit_receive_status <= 1'b1;
			else if (wait_release & transmit_receive_status & i_ninth_clk)
				transmit_receive_status <= 1'b0;
			else if (disabling | set_lrel | i_stop_det)
				transmit_receive_status <= 1'b0;
		end
	end

	// wait release is a one-cycle pulse from a control write
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			wait_release <= 1'b0;
		else
			wait_release <= wr_ctrl & i_wdata[BIT_WREL] & i_in_wait;
	end

	// one timer shared by ninth clock high and stop setup
	logic t_load;
	logic [TWIDTH-1:0] t_count;
	logic t_done;
	scc_timer #(.WIDTH(TWIDTH)) u_timer (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_load(t_load),
		.i_count(t_count),
		.o_done(t_done)
	);

	// stop starts only in wait; on ninth clock with wait timing 0, scl is left released
	wire stop_go = stop_trigger & controller_enable & i_in_wait;
	wire ninth_stop = ~wait_timing_select & i_ninth_clk;

	// stop sequence
	always_comb begin
		next_state = state;
		next_drive = drive;
		t_load = 1'b0;
		t_count = TWIDTH'(STOP_SETUP_CYC);
		unique case (state)
			SCC_IDLE: begin
				if (stop_go) begin
					next_state = SCC_SDA_LOW;
					next_drive = '{scl_oe: ~ninth_stop, sda_oe: 1'b1};
					t_load = 1'b1;
					t_count = TWIDTH'(SCL_HALF_CYC);
				end
			end
			SCC_SDA_LOW: begin
				if (t_done) begin
					next_state = SCC_SCL_HIGH;
					next_drive.scl_oe = 1'b0;
				end
			end
			SCC_SCL_HIGH: begin
				if (scl_high) begin
					next_state = SCC_SETUP;
					t_load = 1'b1;
				end
			end
			SCC_SETUP: begin
				if (t_done) begin
					next_state = SCC_DONE;
					next_drive.sda_oe = 1'b0;
				end
			end
			SCC_DONE: begin
				next_state = SCC_IDLE;
			end
			default: begin
				next_state = SCC_IDLE;
				next_drive = '0;
			end
		endcase
		if (abort) begin
			next_state = SCC_IDLE;
			next_drive = '0;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= SCC_IDLE;
			drive <= '0;
		end else begin
			state <= next_state;
			drive <= next_drive;
		end
	end

	// acknowledge drive on ninth clock when receiving
	wire ack_drive = ack_enable & i_ninth_clk & i_receiving & ~transmit_receive_status;

	// pins: drive low only, released otherwise
	assign o_scl_out = 1'b0;
	assign o_sda_out = 1'b0;
	assign o_scl_oe = drive.scl_oe;
	assign o_sda_oe = drive.sda_oe | (ack_drive & (state == SCC_IDLE));
	assign o_stop_busy = (state != SCC_IDLE);
	assign o_wait_release = wait_release;

	// read mux; trigger bits always read back 0
	wire [7:0] ctrl_rd = {controller_enable, 3'h0, wait_timing_select, ack_enable, 2'h0};
	wire [7:0] stat_rd = {master_status_flag, 3'h0, transmit_receive_status, 3'h0};
	wire [7:0] flag_rd = {7'h00, reservation_disable};
	wire [7:0] rd_mux = (i_addr == ADDR_CTRL) ? ctrl_rd :
		(i_addr == ADDR_STAT) ? stat_rd :
		(i_addr == ADDR_FLAG) ? flag_rd : 8'h00;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			o_rdata <= 8'h00;
		else if (i_rd)
			o_rdata <= rd_mux;
		else
			o_rdata <= 8'h00;
	end
endmodule

// ==== verif/scc_stop_ctrl_monitor.sv ====
/*
 port checker for the stop condition control.
 assumes a bind from the bench and one clock domain.
*/
`timescale 1ns/1ns
module scc_stop_ctrl_monitor
	import scc_pkg::*;
(
	// clock, reset and register port
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	// engine events, pins and state
	input wire logic i_ninth_clk,
	input wire logic i_start_gen,
	input wire logic i_stop_det,
	input wire logic i_scl,
	input wire logic o_scl_oe,
	input wire logic o_sda_oe,
	input wire logic o_stop_busy,
	input wire logic o_wait_release
);
	// write decodes
	wire logic wrel_wr = i_wr && i_addr == ADDR_CTRL && i_wdata[BIT_WREL];
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// event followed by a status read
	sequence s_start_rd; i_start_gen ##2 (i_rd && i_addr == ADDR_STAT); endsequence
	sequence s_stop_rd; i_stop_det ##2 (i_rd && i_addr == ADDR_STAT); endsequence
	property p_no_stray; $fell(o_sda_oe) && !o_scl_oe && !$past(i_ninth_clk) |-> $past(o_stop_busy); endproperty
	a_no_stray: assert property (p_no_stray) else $error("stray stop");
	property p_setup; $fell(o_sda_oe) && $past(o_stop_busy) && !$past(i_wr) && !$past(i_wr, 2) |-> $past(i_scl, 99);
	endproperty
	a_setup: assert property (p_setup) else $error("short stop setup");
	property p_order; $fell(o_scl_oe) && o_stop_busy |-> o_sda_oe; endproperty
	a_order: assert property (p_order) else $error("sda not low first");
	property p_bound; $rose(o_stop_busy) |-> ##[1:400] !o_stop_busy; endproperty
	a_bound: assert property (p_bound) else $error("stop never ends");
	property p_rd0; i_rd && i_addr == ADDR_CTRL |=> !o_rdata[BIT_STOP]; endproperty
	a_rd0: assert property (p_rd0) else $error("stop bit read high");
	property p_wrel; o_wait_release |-> $past(wrel_wr) || $past(wrel_wr, 2); endproperty
	a_wrel: assert property (p_wrel) else $error("release without write");
	property p_mset; s_start_rd |=> o_rdata[BIT_MSTS]; endproperty
	a_mset: assert property (p_mset) else $error("master flag not set");
	property p_mclr; s_stop_rd |=> !o_rdata[BIT_MSTS]; endproperty
	a_mclr: assert property (p_mclr) else $error("master flag not cleared");
	property p_once; $fell(o_stop_busy) |=> !o_stop_busy [*8]; endproperty
	a_once: assert property (p_once) else $error("stop restarted");
endmodule

// ==== verif/scc_bus_model.sv ====
/*
 remote bus device: pull-ups on both lines and scl stretching.
 assumes open-drain enables from the controller on the same clock.
*/
`timescale 1ns/1ns
module scc_bus_model (
	// clock and controller enables
	input wire logic i_clk,
	input wire logic i_scl_oe,
	input wire logic i_sda_oe,
	input wire logic [7:0] i_stretch,
	// resolved lines
	output logic o_scl,
	output logic o_sda
);
	logic [7:0] hold = 8'h00;
	// keeps scl low a while after the controller lets go
	always_ff @(posedge i_clk) begin
		if (i_scl_oe) begin
			hold <= i_stretch;
		end else if (hold != 8'h00) begin
			hold <= hold - 8'h01;
		end
	end
	// pulled-up lines; the stop must wait for scl high
	assign o_scl = !(i_scl_oe || hold != 8'h00);
	assign o_sda = !i_sda_oe;
endmodule

// ==== verif/scc_tb.sv ====
/*
 self-checking bench for the stop condition control.
 assumes the bus model as far side and a 25 MHz clock.
*/
`timescale 1ns/1ns
module testbench
	import scc_pkg::*;
;
	logic i_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_in_wait = 1'b0, i_ninth_clk = 1'b0;
	logic i_receiving = 1'b0, i_transmit_set = 1'b0, i_start_gen = 1'b0, i_stop_det = 1'b0, i_arb_lost = 1'b0;
	logic [1:0] i_addr = 2'h0;
	logic [7:0] i_wdata = 8'h00, stretch = 8'h00, o_rdata;
	logic i_scl, i_sda, o_scl_oe, o_sda_oe, o_stop_busy, o_wait_release, o_scl_out, o_sda_out;
	int fail_count = 0, num_checks = 0;
	// clock, design and far side
	always #20 i_clk = ~i_clk;
	scc_stop_ctrl uut (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_in_wait, .i_ninth_clk,
		.i_receiving, .i_transmit_set, .i_start_gen, .i_stop_det, .i_arb_lost, .i_scl, .i_sda, .o_scl_out,
		.o_scl_oe, .o_sda_out, .o_sda_oe, .o_stop_busy, .o_wait_release);
	scc_bus_model bus (.i_clk, .i_scl_oe(o_scl_oe), .i_sda_oe(o_sda_oe), .i_stretch(stretch), .o_scl(i_scl),
		.o_sda(i_sda));
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask
	task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd_chk(input string name, input logic [1:0] a, input logic [7:0] m, input logic [7:0] exp);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk(name, exp, o_rdata & m);
	endtask
	// k: 0 start made, 1 stop seen, 2 transmit status
	task automatic pulse(input int k);
		@(posedge i_clk);
		{i_start_gen, i_stop_det, i_transmit_set} <= 3'b100 >> k;
		@(posedge i_clk);
		{i_start_gen, i_stop_det, i_transmit_set} <= 3'b000;
	endtask
	task automatic wait_busy(input logic v, output int n);
		n = 0;
		while (o_stop_busy !== v) begin
			// look after the edge, once the state has settled
			@(posedge i_clk);
			#1;
			n++;
			if (n > 600) begin
				fail_count++;
				give_verdict();
			end
		end
	endtask
	task automatic t_regs();
		for (int i = 0; i < 4; i++) rd_chk("reset", 2'(i), 8'hff, 8'h00);
		reg_wr(ADDR_CTRL, 8'h8c);
		rd_chk("ctrl", ADDR_CTRL, 8'hff, 8'h8c);
		reg_wr(ADDR_FLAG, 8'h01);
		rd_chk("flag", ADDR_FLAG, 8'hff, 8'h01);
		reg_wr(ADDR_FLAG, 8'h00);
		$display("regs done");
	endtask
	task automatic t_nostop();
		logic [7:0] bad [2] = '{8'h83, 8'h01};
		@(posedge i_clk) i_in_wait <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			reg_wr(ADDR_CTRL, bad[i]);
			repeat (20) @(posedge i_clk);
			chk("no stop", 8'h00, {6'h0, o_stop_busy, o_sda_oe});
		end
		$display("nostop done");
	endtask
	task automatic t_stop();
		int n;
		// the last scenario disabled the controller; enable it, wait timing 1 first
		reg_wr(ADDR_CTRL, 8'h88);
		pulse(0);
		rd_chk("master", ADDR_STAT, 8'h80, 8'h80);
		stretch = 8'd20;
		reg_wr(ADDR_CTRL, 8'h89);
		rd_chk("ctrl", ADDR_CTRL, 8'hff, 8'h88);
		wait_busy(1'b1, n);
		wait_busy(1'b0, n);
		// a few cycles went by in the read before counting
		chk("length", 8'h01, {7'h0, n >= SCL_HALF_CYC + STOP_SETUP_CYC - 4});
		chk("lines", 8'h03, {6'h0, i_scl, i_sda});
		chk("pins low", 8'h00, {6'h0, o_scl_out, o_sda_out});
		repeat (10) @(posedge i_clk);
		chk("rearm", 8'h00, {7'h0, o_stop_busy});
		pulse(1);
		rd_chk("master clr", ADDR_STAT, 8'h80, 8'h00);
		$display("stop done");
	endtask
	task automatic t_ack();
		@(posedge i_clk) {i_in_wait, i_receiving, i_ninth_clk} <= 3'b011;
		reg_wr(ADDR_CTRL, 8'h84);
		#1 chk("ack", 8'h01, {7'h0, o_sda_oe});
		reg_wr(ADDR_CTRL, 8'h80);
		#1 chk("no ack", 8'h00, {7'h0, o_sda_oe});
		$display("ack done");
	endtask
	task automatic t_wrel();
		logic seen = 1'b0;
		@(posedge i_clk) {i_in_wait, i_receiving, i_ninth_clk} <= 3'b101;
		pulse(2);
		rd_chk("trc", ADDR_STAT, 8'h08, 8'h08);
		reg_wr(ADDR_CTRL, 8'ha0);
		for (int i = 0; i < 3; i++) begin
			#1 seen = seen | o_wait_release;
			@(posedge i_clk);
		end
		chk("wrel", 8'h01, {7'h0, seen});
		rd_chk("trc clr", ADDR_STAT, 8'h08, 8'h00);
		chk("sda free", 8'h00, {7'h0, o_sda_oe});
		$display("wrel done");
	endtask
	task automatic t_abort();
		int n;
		stretch = 8'd0;
		pulse(0);
		reg_wr(ADDR_CTRL, 8'h81);
		repeat (2) @(posedge i_clk);
		#1 chk("ninth", 8'h05, {5'h0, o_stop_busy, o_scl_oe, o_sda_oe});
		reg_wr(ADDR_CTRL, 8'hc0);
		wait_busy(1'b0, n);
		chk("abort", 8'h01, {7'h0, n < 4});
		rd_chk("master lrel", ADDR_STAT, 8'h80, 8'h00);
		$display("abort done");
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// reset, then the scenarios in turn
	initial begin
		repeat (16) @(posedge i_clk);
		i_reset_n <= 1'b1;
		t_regs();
		t_nostop();
		t_stop();
		t_ack();
		t_wrel();
		t_abort();
		give_verdict();
	end
endmodule
bind scc_stop_ctrl scc_stop_ctrl_monitor mon (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
	.i_ninth_clk, .i_start_gen, .i_stop_det, .i_scl, .o_scl_oe, .o_sda_oe, .o_stop_busy, .o_wait_release);
